// ---- rtl/crsp_defs.svh ----
// Register offsets, field positions, reset values and timing counts for the CODEC and converter ports
`ifndef CRSP_DEFS_SVH
`define CRSP_DEFS_SVH
`define CRSP_OFS_CONV        6'h10
`define CRSP_OFS_CODEC       6'h14
`define CRSP_ZERO32          32'h0000_0000
`define CRSP_RDY_BIT         31
`define CRSP_WIP_BIT         30
`define CRSP_DIR_BIT         23
`define CRSP_IDX_HI          22
`define CRSP_IDX_LO          16
`define CRSP_DAT_HI          15
`define CRSP_DAT_LO          0
`define CRSP_MADR_HI         31
`define CRSP_MADR_LO         25
`define CRSP_MDIR_BIT        24
`define CRSP_BUSY_BIT        23
`define CRSP_OFF_BIT         22
`define CRSP_P1_BIT          21
`define CRSP_P2_BIT          20
`define CRSP_REC_BIT         19
`define CRSP_ZERO_HI         29
`define CRSP_ZERO_LO         24
`define CRSP_UNDEF_HI        18
`define CRSP_UNDEF_LO        16
`define CRSP_SLOT_DIR_BIT    19
`define CRSP_SLOT_IDX_HI     18
`define CRSP_SLOT_IDX_LO     12
`define CRSP_SLOT_VAL_HI     19
`define CRSP_SLOT_VAL_LO     4
`define CRSP_TMO_VALUE       16'hFFFF
`define CRSP_BUSY_MAX_NS     12
`define CRSP_CLK_NS          4
`define CRSP_BUSY_MAX_CYC    ((`CRSP_BUSY_MAX_NS) / (`CRSP_CLK_NS))
`define CRSP_MEM_DEPTH       128
`define CRSP_MEM_LAT         3'h2
`define CRSP_RSP_TIMEOUT     8'hFF
`endif

// ---- rtl/crsp_pkg.sv ----
// Types shared by the CODEC and converter port modules
package crsp_pkg;
   typedef enum logic [1:0] {CRSP_C_IDLE, CRSP_C_SEND, CRSP_C_WAIT} crsp_cstate_t;
   typedef enum logic [1:0] {CRSP_M_IDLE, CRSP_M_WAIT, CRSP_M_DONE} crsp_mstate_t;
endpackage : crsp_pkg

// ---- rtl/crsp_conv_mem.sv ----
// Converter RAM with fixed access latency and busy handshake
`timescale 1ns/1ps
`include "crsp_defs.svh"
module crsp_conv_mem
   import crsp_pkg::*;
(
   input  wire logic        clk_i,     // Core clock
   input  wire logic        srst_i,    // Sync reset
   input  wire logic        ce_i,      // Clock enable
   input  wire logic        start_i,   // Access request pulse
   input  wire logic        wr_i,      // 1 write, 0 read
   input  wire logic [6:0]  idx_i,     // Location
   input  wire logic [15:0] wdata_i,   // Write data
   output logic             busy_o,    // Access pending
   output logic             done_o,    // Finished pulse
   output logic [15:0]      rdata_o    // Read data
);
   typedef struct packed {
      crsp_mstate_t st;
      logic [2:0]   cnt;
      logic         wr;
      logic [6:0]   idx;
      logic [15:0]  wd;
      logic [15:0]  rd;
      logic         done;
   } crsp_mem_st_t;

   crsp_mem_st_t s, next_s;
   logic [15:0]  mem [0:`CRSP_MEM_DEPTH-1];

   always_comb begin
      next_s      = s;
      next_s.done = 1'b0;
      case (s.st)
         CRSP_M_IDLE: begin
            if (start_i) begin
               next_s.st  = CRSP_M_WAIT;
               next_s.cnt = `CRSP_MEM_LAT;
               next_s.wr  = wr_i;
               next_s.idx = idx_i;
               next_s.wd  = wdata_i;
            end
         end
         CRSP_M_WAIT: begin
            if (s.cnt == 3'h0) begin
               next_s.st = CRSP_M_DONE;
               if (!s.wr) next_s.rd = mem[s.idx];
            end else begin
               next_s.cnt = s.cnt - 3'h1;
            end
         end
         CRSP_M_DONE: begin
            next_s.st   = CRSP_M_IDLE;
            next_s.done = 1'b1;
         end
         default: next_s.st = CRSP_M_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s <= '0;
      end else if (ce_i) begin
         s <= next_s;
         if (s.st == CRSP_M_WAIT && s.cnt == 3'h0 && s.wr) mem[s.idx] <= s.wd;
      end
   end

   assign busy_o  = (s.st != CRSP_M_IDLE) || s.done;  // Held through the done pulse cycle
   assign done_o  = s.done;
   assign rdata_o = s.rd;
endmodule : crsp_conv_mem

// ---- rtl/crsp_slot_link.sv ----
// Sequencer that carries one CODEC command out on the link slots and, for a read, takes the status slots back
`timescale 1ns/1ps
`include "crsp_defs.svh"
module crsp_slot_link
   import crsp_pkg::*;
(
   input  wire logic        clk_i,       // Core clock
   input  wire logic        srst_i,      // Sync reset
   input  wire logic        ce_i,        // Clock enable
   input  wire logic        start_i,     // Command pulse
   input  wire logic        rd_i,        // 1 read
   input  wire logic [6:0]  idx_i,       // Register index
   input  wire logic [15:0] wval_i,      // Write value
   output logic             slot_vld_o,  // Command slot request
   output logic [19:0]      slot_addr_o, // Address slot
   output logic [19:0]      slot_data_o, // Data slot
   input  wire logic        slot_ack_i,  // Slots sent on frame
   input  wire logic        stat_vld_i,  // Status slots received
   input  wire logic [19:0] stat_addr_i, // Status address slot
   input  wire logic [19:0] stat_data_i, // Status data slot
   output logic             done_o,      // Finished pulse
   output logic [15:0]      rval_o       // Read value
);
   typedef struct packed {
      crsp_cstate_t st;
      logic         rd;
      logic [6:0]   idx;
      logic [15:0]  wv;
      logic [15:0]  rv;
      logic [7:0]   tmo;
      logic         done;
   } crsp_lnk_st_t;

   crsp_lnk_st_t s, next_s;

   always_comb begin
      next_s      = s;
      next_s.done = 1'b0;
      case (s.st)
         CRSP_C_IDLE: begin
            if (start_i) begin
               next_s.st  = CRSP_C_SEND;
               next_s.rd  = rd_i;
               next_s.idx = idx_i;
               next_s.wv  = wval_i;
            end
         end
         CRSP_C_SEND: begin
            if (slot_ack_i) begin
               if (s.rd) begin
                  next_s.st  = CRSP_C_WAIT;
                  next_s.tmo = `CRSP_RSP_TIMEOUT;
               end else begin
                  next_s.st   = CRSP_C_IDLE;
                  next_s.done = 1'b1;
               end
            end
         end
         CRSP_C_WAIT: begin
            if (stat_vld_i && stat_addr_i[`CRSP_SLOT_IDX_HI:`CRSP_SLOT_IDX_LO] == s.idx) begin
               next_s.rv   = stat_data_i[`CRSP_SLOT_VAL_HI:`CRSP_SLOT_VAL_LO];
               next_s.st   = CRSP_C_IDLE;
               next_s.done = 1'b1;
            end else if (s.tmo == 8'h00) begin
               next_s.rv   = `CRSP_TMO_VALUE;
               next_s.st   = CRSP_C_IDLE;
               next_s.done = 1'b1;
            end else begin
               next_s.tmo = s.tmo - 8'h01;
            end
         end
         default: next_s.st = CRSP_C_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) s <= '0;
      else if (ce_i) s <= next_s;
   end

   assign slot_vld_o  = (s.st == CRSP_C_SEND);
   assign slot_addr_o = {s.rd, s.idx, 12'h000};
   assign slot_data_o = {s.wv, 4'h0};
   assign done_o      = s.done;
   assign rval_o      = s.rv;
endmodule : crsp_slot_link

// ---- rtl/crsp_top.sv ----
// CODEC command/result port and converter RAM port on the I/O register space
`timescale 1ns/1ps
`include "crsp_defs.svh"
module crsp_top
   import crsp_pkg::*;
(
   input  wire logic        CORE_CLK_I,    // Core clock
   input  wire logic        SRST_I,        // Sync reset, high
   input  wire logic        CE_I,          // Clock enable
   input  wire logic [5:0]  IO_ADDR_I,     // I/O byte address
   input  wire logic        IO_WR_I,       // Write strobe
   input  wire logic        IO_RD_I,       // Read strobe
   input  wire logic [3:0]  IO_BE_I,       // Byte enables
   input  wire logic [31:0] IO_WDATA_I,    // Write data
   output logic [31:0]      IO_RDATA_O,    // Read data
   output logic             SLOT_VLD_O,    // Command slot request
   output logic [19:0]      SLOT_ADDR_O,   // Command address slot
   output logic [19:0]      SLOT_DATA_O,   // Command data slot
   input  wire logic        SLOT_ACK_I,    // Slot sent
   input  wire logic        STAT_VLD_I,    // Status slots valid
   input  wire logic [19:0] STAT_ADDR_I,   // Status address slot
   input  wire logic [19:0] STAT_DATA_I,   // Status data slot
   output logic             CONV_OFF_O,    // Converter disabled
   output logic             PLAY_ONE_HOLD_O, // Channel 1 accumulator hold
   output logic             PLAY_TWO_HOLD_O, // Channel 2 accumulator hold
   output logic             RECORD_HOLD_O  // Record accumulator hold
);
   typedef struct packed {
      logic        rdy;
      logic        dir;
      logic [6:0]  cidx;
      logic [15:0] cval;
      logic        cstart;
      logic [6:0]  midx;
      logic        mdir;
      logic        mstart;
      logic        conv_off;
      logic        p1;
      logic        p2;
      logic        rec;
      logic [2:0]  undef;
      logic [15:0] mval;
      logic [31:0] rdata;
      logic        lbusy;
   } crsp_top_st_t;

   crsp_top_st_t s, next_s;
   logic         lnk_done;
   logic [15:0]  lnk_rval;
   logic         lnk_busy;
   logic         mem_busy;
   logic         mem_done;
   logic [15:0]  mem_rdata;
   logic         codec_txn_active;
   logic         sel_conv;
   logic         sel_codec;
   logic         full_word;

   function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
      hit = (a[5:2] == ofs[5:2]);
   endfunction : hit

   assign sel_conv  = hit(IO_ADDR_I, `CRSP_OFS_CONV);
   assign sel_codec = hit(IO_ADDR_I, `CRSP_OFS_CODEC);
   assign full_word = (IO_BE_I == 4'hF);
   assign lnk_busy  = s.lbusy;
   assign codec_txn_active       = lnk_busy || s.cstart;

   always_comb begin
      next_s        = s;
      next_s.cstart = 1'b0;
      next_s.mstart = 1'b0;
      if (IO_WR_I && sel_codec && full_word) begin
         next_s.cstart = !lnk_busy;
         next_s.rdy    = 1'b0;
         next_s.dir    = IO_WDATA_I[`CRSP_DIR_BIT];
         next_s.cidx   = IO_WDATA_I[`CRSP_IDX_HI:`CRSP_IDX_LO];
         next_s.cval   = IO_WDATA_I[`CRSP_DAT_HI:`CRSP_DAT_LO];
      end
      if (lnk_done) begin
         next_s.rdy = s.dir;
         if (s.dir) next_s.cval = lnk_rval;
      end
      if (IO_WR_I && sel_conv && full_word) begin
         next_s.midx     = IO_WDATA_I[`CRSP_MADR_HI:`CRSP_MADR_LO];
         next_s.mdir     = IO_WDATA_I[`CRSP_MDIR_BIT];
         next_s.conv_off = IO_WDATA_I[`CRSP_OFF_BIT];
         next_s.p1       = IO_WDATA_I[`CRSP_P1_BIT];
         next_s.p2       = IO_WDATA_I[`CRSP_P2_BIT];
         next_s.rec      = IO_WDATA_I[`CRSP_REC_BIT];
         next_s.undef    = IO_WDATA_I[`CRSP_UNDEF_HI:`CRSP_UNDEF_LO];
         next_s.mval     = IO_WDATA_I[`CRSP_DAT_HI:`CRSP_DAT_LO];
         next_s.mstart   = !mem_busy;
      end
      if (mem_done && !s.mdir) next_s.mval = mem_rdata;
      if (s.cstart) next_s.lbusy = 1'b1;
      else if (lnk_done) next_s.lbusy = 1'b0;
      next_s.rdata = `CRSP_ZERO32;
      if (IO_RD_I && sel_codec) begin
         next_s.rdata[`CRSP_RDY_BIT]                 = s.rdy;
         next_s.rdata[`CRSP_WIP_BIT]                 = codec_txn_active;
         next_s.rdata[`CRSP_DIR_BIT]                 = s.dir;
         next_s.rdata[`CRSP_IDX_HI:`CRSP_IDX_LO]     = s.cidx;
         next_s.rdata[`CRSP_DAT_HI:`CRSP_DAT_LO]     = s.dir ? s.cval : 16'h0000;
      end else if (IO_RD_I && sel_conv) begin
         next_s.rdata = {s.midx, s.mdir, mem_busy || s.mstart, s.conv_off,
                         s.p1, s.p2, s.rec, s.undef, s.mval};
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (SRST_I) s <= '0;
      else if (CE_I) s <= next_s;
   end

   crsp_slot_link u_link (
      .clk_i       (CORE_CLK_I),
      .srst_i      (SRST_I),
      .ce_i        (CE_I),
      .start_i     (s.cstart),
      .rd_i        (s.dir),
      .idx_i       (s.cidx),
      .wval_i      (s.cval),
      .slot_vld_o  (SLOT_VLD_O),
      .slot_addr_o (SLOT_ADDR_O),
      .slot_data_o (SLOT_DATA_O),
      .slot_ack_i  (SLOT_ACK_I),
      .stat_vld_i  (STAT_VLD_I),
      .stat_addr_i (STAT_ADDR_I),
      .stat_data_i (STAT_DATA_I),
      .done_o      (lnk_done),
      .rval_o      (lnk_rval)
   );

   crsp_conv_mem u_mem (
      .clk_i   (CORE_CLK_I),
      .srst_i  (SRST_I),
      .ce_i    (CE_I),
      .start_i (s.mstart),
      .wr_i    (s.mdir),
      .idx_i   (s.midx),
      .wdata_i (s.mval),
      .busy_o  (mem_busy),
      .done_o  (mem_done),
      .rdata_o (mem_rdata)
   );

   assign IO_RDATA_O      = s.rdata;
   assign CONV_OFF_O      = s.conv_off;
   assign PLAY_ONE_HOLD_O = s.p1;
   assign PLAY_TWO_HOLD_O = s.p2;
   assign RECORD_HOLD_O   = s.rec;

   property p_cmd_start;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (CE_I && IO_WR_I && sel_codec && full_word && !lnk_busy) |=> s.cstart;
   endproperty
   a_cmd_start: assert property (p_cmd_start) else $error("command write did not start");

   property p_busy_rise;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (CE_I && IO_WR_I && sel_conv && full_word && !mem_busy) ##1 CE_I[*2] |-> ##[0:1] mem_busy;
   endproperty
   a_busy_rise: assert property (p_busy_rise) else $error("busy late");

   property p_busy_clear;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (CE_I && mem_done) |=> (!mem_busy || !CE_I);
   endproperty
   a_busy_clear: assert property (p_busy_clear) else $error("busy stuck");

   property p_rdy_only_read;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      s.rdy |-> s.dir;
   endproperty
   a_rdy_only_read: assert property (p_rdy_only_read) else $error("valid on write");

   property p_zero_bits;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      $past(IO_RD_I && sel_codec && CE_I) |-> (IO_RDATA_O[`CRSP_ZERO_HI:`CRSP_ZERO_LO] == 6'h00);
   endproperty
   a_zero_bits: assert property (p_zero_bits) else $error("reserved bits set");

   property p_rdy_clears;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (CE_I && IO_WR_I && sel_codec && full_word && !lnk_done) |=> !s.rdy;
   endproperty
   a_rdy_clears: assert property (p_rdy_clears) else $error("stale valid");

   property p_off_follows;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (CE_I && IO_WR_I && sel_conv && full_word) |=> (CONV_OFF_O == $past(IO_WDATA_I[`CRSP_OFF_BIT]));
   endproperty
   a_off_follows: assert property (p_off_follows) else $error("converter disable wrong");

   property p_hold_follows;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (CE_I && IO_WR_I && sel_conv && full_word) |=>
         ({PLAY_ONE_HOLD_O, PLAY_TWO_HOLD_O, RECORD_HOLD_O} == $past(IO_WDATA_I[`CRSP_P1_BIT:`CRSP_REC_BIT]));
   endproperty
   a_hold_follows: assert property (p_hold_follows) else $error("hold bits wrong");

   property p_wip_done;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (CE_I && lnk_done) |=> !lnk_busy;
   endproperty
   a_wip_done: assert property (p_wip_done) else $error("in-progress stuck");

   property p_slot_cmd;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (CE_I && s.cstart) |=> (SLOT_VLD_O && SLOT_ADDR_O[`CRSP_SLOT_DIR_BIT] == $past(s.dir)
         && SLOT_ADDR_O[`CRSP_SLOT_IDX_HI:`CRSP_SLOT_IDX_LO] == $past(s.cidx));
   endproperty
   a_slot_cmd: assert property (p_slot_cmd) else $error("command slot wrong");

   property p_slot_val;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (CE_I && s.cstart) |=> (SLOT_DATA_O[`CRSP_SLOT_VAL_HI:`CRSP_SLOT_VAL_LO] == $past(s.cval));
   endproperty
   a_slot_val: assert property (p_slot_val) else $error("data slot wrong");

   property p_slot_hold;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (SLOT_VLD_O && !SLOT_ACK_I) |=> (SLOT_VLD_O && $stable(SLOT_ADDR_O) && $stable(SLOT_DATA_O));
   endproperty
   a_slot_hold: assert property (p_slot_hold) else $error("slot request dropped");

   property p_ack_ends;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (CE_I && SLOT_VLD_O && SLOT_ACK_I) |=> !SLOT_VLD_O;
   endproperty
   a_ack_ends: assert property (p_ack_ends) else $error("slot request after ack");

   property p_done_pulse;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (CE_I && lnk_done) |=> !lnk_done;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("double completion");

   property p_wip_link;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      SLOT_VLD_O |-> codec_txn_active;
   endproperty
   a_wip_link: assert property (p_wip_link) else $error("in-progress low while sending");

   property p_wip_read;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (CE_I && IO_RD_I && sel_codec && lnk_busy) |=> IO_RDATA_O[`CRSP_WIP_BIT];
   endproperty
   a_wip_read: assert property (p_wip_read) else $error("in-progress not reported");

   property p_rdy_read;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (CE_I && lnk_done && s.dir) |=> s.rdy;
   endproperty
   a_rdy_read: assert property (p_rdy_read) else $error("valid missing after read");

   property p_read_value;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (CE_I && lnk_done && s.dir) |=> (s.cval == $past(lnk_rval));
   endproperty
   a_read_value: assert property (p_read_value) else $error("read value not kept");

   property p_result_fields;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (CE_I && IO_RD_I && sel_codec) |=> (IO_RDATA_O[`CRSP_DIR_BIT] == $past(s.dir)
         && IO_RDATA_O[`CRSP_IDX_HI:`CRSP_IDX_LO] == $past(s.cidx));
   endproperty
   a_result_fields: assert property (p_result_fields) else $error("result fields wrong");

   property p_write_no_data;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (CE_I && IO_RD_I && sel_codec && !s.dir) |=> (IO_RDATA_O[`CRSP_DAT_HI:`CRSP_DAT_LO] == 16'h0000);
   endproperty
   a_write_no_data: assert property (p_write_no_data) else $error("data shown after write");

   property p_idle_zero;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (CE_I && !IO_RD_I) |=> (IO_RDATA_O == `CRSP_ZERO32);
   endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("read data outside read");

   property p_reset_zero;
      @(posedge CORE_CLK_I)
      (!SRST_I && $past(SRST_I)) |-> (IO_RDATA_O == `CRSP_ZERO32 && !SLOT_VLD_O && !CONV_OFF_O
         && !PLAY_ONE_HOLD_O && !PLAY_TWO_HOLD_O && !RECORD_HOLD_O);
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("outputs not clear after reset");

   property p_busy_read;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (CE_I && IO_RD_I && sel_conv && mem_busy) |=> IO_RDATA_O[`CRSP_BUSY_BIT];
   endproperty
   a_busy_read: assert property (p_busy_read) else $error("busy not reported");

   property p_busy_bounded;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (CE_I && s.mstart) ##1 CE_I[*6] |-> !mem_busy;
   endproperty
   a_busy_bounded: assert property (p_busy_bounded) else $error("busy too long");

   property p_conv_fields;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (CE_I && IO_RD_I && sel_conv) |=> (IO_RDATA_O[`CRSP_MADR_HI:`CRSP_MADR_LO] == $past(s.midx)
         && IO_RDATA_O[`CRSP_MDIR_BIT] == $past(s.mdir));
   endproperty
   a_conv_fields: assert property (p_conv_fields) else $error("converter fields wrong");

   property p_mem_result;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (CE_I && mem_done && !s.mdir) |=> (s.mval == $past(mem_rdata));
   endproperty
   a_mem_result: assert property (p_mem_result) else $error("RAM value not kept");

   property p_partial_ignored;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      (CE_I && IO_WR_I && sel_conv && !full_word) |=>
         $stable({CONV_OFF_O, PLAY_ONE_HOLD_O, PLAY_TWO_HOLD_O, RECORD_HOLD_O});
   endproperty
   a_partial_ignored: assert property (p_partial_ignored) else $error("partial write taken");

   c_cmd_read:  cover property (@(posedge CORE_CLK_I) s.cstart && s.dir ##[1:300] s.rdy);
   c_cmd_write: cover property (@(posedge CORE_CLK_I) s.cstart && !s.dir ##[1:20] lnk_done);
   c_mem_read:  cover property (@(posedge CORE_CLK_I) s.mstart && !s.mdir ##[1:8] mem_done);
   c_mem_write: cover property (@(posedge CORE_CLK_I) s.mstart && s.mdir ##[1:8] mem_done);
   c_cmd_tmo:   cover property (@(posedge CORE_CLK_I) lnk_done && lnk_rval == `CRSP_TMO_VALUE);
endmodule : crsp_top

// ---- tb/crsp_codec_model.sv ----
// Behavioural CODEC that takes command slots and returns status slots
`timescale 1ns/1ps
module crsp_codec_model (
   input  wire logic        clk_i,       // Core clock
   input  wire logic        srst_i,      // Sync reset
   input  wire logic        slot_vld_i,  // Command slot request
   input  wire logic [19:0] slot_addr_i, // Command address slot
   input  wire logic [19:0] slot_data_i, // Command data slot
   output logic             slot_ack_o,  // Slots taken
   output logic             stat_vld_o,  // Status slots valid
   output logic [19:0]      stat_addr_o, // Status address slot
   output logic [19:0]      stat_data_o  // Status data slot
);
   logic [15:0] mem [128];
   logic [6:0]  ridx;
   logic [3:0]  cnt;
   logic        slow;
   logic        pend;
   logic        mute = 1'b0;  // Set by the bench to drop answers
   always @(posedge clk_i) begin
      slot_ack_o  <= 1'b0;
      stat_vld_o  <= 1'b0;
      // Idle status lines keep toggling
      stat_addr_o <= ~stat_addr_o;
      stat_data_o <= ~stat_data_o;
      if (srst_i) begin
         cnt         <= 4'h0;
         slow        <= 1'b0;
         pend        <= 1'b0;
         stat_addr_o <= 20'h0_0000;
         stat_data_o <= 20'h0_0000;
         foreach (mem[i]) mem[i] <= 16'h0000;
      end else if (pend) begin
         if (cnt == 4'h0) begin
            stat_vld_o  <= !mute;
            stat_addr_o <= {1'b0, ridx, 12'h000};
            stat_data_o <= {mem[ridx], 4'h0};
            pend        <= 1'b0;
         end else begin
            cnt <= cnt - 4'h1;
         end
      end else if (slot_vld_i && !slot_ack_o) begin
         // Alternate prompt and slow answers
         if (cnt == (slow ? 4'h6 : 4'h1)) begin
            slot_ack_o <= 1'b1;
            slow       <= !slow;
            cnt        <= slow ? 4'h0 : 4'h5;
            if (slot_addr_i[19]) begin
               pend <= 1'b1;
               ridx <= slot_addr_i[18:12];
            end else begin
               mem[slot_addr_i[18:12]] <= slot_data_i[19:4];
            end
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule : crsp_codec_model

// ---- tb/crsp_top_bench.sv ----
// Self-checking bench for the CODEC command port and converter RAM port
`timescale 1ns/1ps
module crsp_top_bench
   import crsp_pkg::*;
;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        io_wr = 1'b0;
   logic        io_rd = 1'b0;
   logic [5:0]  io_addr = 6'h00;
   logic [3:0]  io_be = 4'hF;
   logic [31:0] io_wdata = 32'h0000_0000;
   wire  [31:0] io_rdata;
   wire         slot_vld, slot_ack, stat_vld, conv_off, p1_hold, p2_hold, rec_hold;
   wire  [19:0] slot_addr, slot_data, stat_addr, stat_data;
   logic [31:0] d;
   logic        b;
   logic [6:0]  idx;
   logic [15:0] val;
   logic [3:0]  fl;
   int          cyc = 0;
   int          n_mismatch = 0;
   int          num_checks = 0;

   always #2 clk = ~clk;

   crsp_top u_dut (.CORE_CLK_I(clk), .SRST_I(srst), .CE_I(1'b1), .IO_ADDR_I(io_addr), .IO_WR_I(io_wr),
      .IO_RD_I(io_rd), .IO_BE_I(io_be), .IO_WDATA_I(io_wdata), .IO_RDATA_O(io_rdata), .SLOT_VLD_O(slot_vld),
      .SLOT_ADDR_O(slot_addr), .SLOT_DATA_O(slot_data), .SLOT_ACK_I(slot_ack), .STAT_VLD_I(stat_vld),
      .STAT_ADDR_I(stat_addr), .STAT_DATA_I(stat_data), .CONV_OFF_O(conv_off), .PLAY_ONE_HOLD_O(p1_hold),
      .PLAY_TWO_HOLD_O(p2_hold), .RECORD_HOLD_O(rec_hold));

   crsp_codec_model u_codec (.clk_i(clk), .srst_i(srst), .slot_vld_i(slot_vld), .slot_addr_i(slot_addr),
      .slot_data_i(slot_data), .slot_ack_o(slot_ack), .stat_vld_o(stat_vld), .stat_addr_o(stat_addr),
      .stat_data_o(stat_data));

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic io_write(input logic [5:0] a, input logic [31:0] v);
      @(posedge clk);
      #1;
      io_addr  = a;
      io_wdata = v;
      io_wr    = 1'b1;
      @(posedge clk);
      #1;
      io_wr = 1'b0;
   endtask : io_write

   task automatic io_read(input logic [5:0] a, output logic [31:0] v);
      @(posedge clk);
      #1;
      io_addr = a;
      io_rd   = 1'b1;
      @(posedge clk);
      #1;
      io_rd = 1'b0;
      v     = io_rdata;
   endtask : io_read

   // Poll a flag until low, then read once more for settled fields
   task automatic wait_clear(input logic [5:0] a, input int bitn, output logic [31:0] v);
      int i;
      v = 32'hFFFF_FFFF;
      for (i = 0; i < 400 && v[bitn] !== 1'b0; i++) io_read(a, v);
      chk("flag clears", v[bitn], 1'b0);
      io_read(a, v);
   endtask : wait_clear

   task automatic tend(input string name);
      $display("test %s done, mismatches so far %0d", name, n_mismatch);
   endtask : tend

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         conclude();
      end
   end

   initial begin
      void'($urandom(93073));
      repeat (5) @(posedge clk);
      #1;
      srst = 1'b0;
      io_read(6'h10, d);
      chk("conv reset", d, 32'h0000_0000);
      io_read(6'h14, d);
      chk("codec reset", d, 32'h0000_0000);
      chk("hold reset", {conv_off, p1_hold, p2_hold, rec_hold}, 4'h0);
      tend("reset");
      for (int k = 0; k < 6; k++) begin
         idx = (k == 0) ? 7'h7F : (k == 1) ? 7'h00 : 7'($urandom);
         val = (k == 0) ? 16'hFFFF : 16'($urandom);
         io_write(6'h14, {8'h00, 1'b0, idx, val});
         io_read(6'h14, d);
         chk("write in progress", d[30], 1'b1);
         wait_clear(6'h14, 30, d);
         chk("codec reg", u_codec.mem[idx], val);
         chk("no valid after write", d[31], 1'b0);
         io_write(6'h14, {8'h00, 1'b1, idx, 16'h0000});
         wait_clear(6'h14, 30, d);
         chk("read result", d, {2'b10, 6'h00, 1'b1, idx, val});
      end
      u_codec.mute = 1'b1;
      io_write(6'h14, {8'h00, 1'b1, idx, 16'h0000});
      wait_clear(6'h14, 30, d);
      chk("read timeout", d, {2'b10, 6'h00, 1'b1, idx, 16'hFFFF});
      u_codec.mute = 1'b0;
      tend("codec");
      for (int k = 0; k < 6; k++) begin
         idx = 7'($urandom);
         val = 16'($urandom);
         fl  = (k < 4) ? (4'h8 >> k) : 4'($urandom);
         io_write(6'h10, {idx, 1'b1, 1'b0, fl, 3'b000, val});
         io_read(6'h10, d);
         b = d[23];
         io_read(6'h10, d);
         chk("busy rises", b | d[23], 1'b1);
         wait_clear(6'h10, 23, d);
         chk("hold outs", {conv_off, p1_hold, p2_hold, rec_hold}, fl);
         io_write(6'h10, {idx, 1'b0, 1'b0, fl, 3'b000, 16'h0000});
         wait_clear(6'h10, 23, d);
         chk("mem value", d[15:0], val);
         chk("conv fields", d[31:19], {idx, 2'b00, fl});
      end
      io_be = 4'h3;
      io_write(6'h10, {9'h000, ~fl[3], 22'h00_0000});
      io_be = 4'hF;
      chk("partial write ignored", conv_off, fl[3]);
      tend("converter");
      conclude();
   end
endmodule : crsp_top_bench
